// [common/core_exc_map.vh]
`ifndef CORE_EXC_MAP_VH
`define CORE_EXC_MAP_VH

// processing modes, low five bits of the status word
`define MODE_USR 5'h10
`define MODE_FIQ 5'h11
`define MODE_IRQ 5'h12
`define MODE_SVC 5'h13
`define MODE_ABT 5'h17
`define MODE_UND 5'h1b
`define MODE_SYS 5'h1f

// status word field positions and reset value
`define SW_T_BIT 5
`define SW_F_BIT 6
`define SW_I_BIT 7
`define SW_RESET 32'h0000_00d3

// exception vector addresses
`define VEC_UND 32'h0000_0004
`define VEC_SWT 32'h0000_0008
`define VEC_ABT 32'h0000_0010
`define VEC_IRQ 32'h0000_0018
`define VEC_FIQ 32'h0000_001c

// entry latency bounds in core cycles
`define LAT_MAX_BLOCK 8'd50
`define LAT_MAX_PLAIN 8'd42
`define LAT_MAX_COMP 8'd22
`define LAT_MIN 8'd5

// register file sizes
`define NUM_GPR 31
`define NUM_SAVED_SW 5

// debug port selects
`define DBG_BP_ADDR 2'h0
`define DBG_WP_ADDR 2'h1
`define DBG_ENABLES 2'h2

// data access sizes
`define SIZE_BYTE 2'h0
`define SIZE_HALF 2'h1
`define SIZE_WORD 2'h2

`endif

// [hw/core_banked_regs.v]
`timescale 1ns/1ps
`default_nettype none
`include "core_exc_map.vh"

module core_banked_regs
(
  input wire sys_clk_i,
  input wire sys_rst_i,
  input wire [4:0] mode_i,
  input wire [3:0] rd_idx_a_i,
  output wire [31:0] rd_a_o,
  input wire [3:0] rd_idx_b_i,
  output wire [31:0] rd_b_o,
  input wire wr_en_i,
  input wire [4:0] wr_mode_i,
  input wire [3:0] wr_idx_i,
  input wire [31:0] wr_data_i,
  input wire sw_wr_i,
  input wire [4:0] sw_mode_i,
  input wire [31:0] sw_data_i,
  output wire [31:0] saved_sw_o
);

  reg [31:0] gpr_r [0:`NUM_GPR-1];
  reg [31:0] saved_r [0:`NUM_SAVED_SW-1];
  integer i;

  // map mode and visible index onto the physical bank; user slots 0..15
  function [4:0] phys;
    input [4:0] m;
    input [3:0] r;
    begin
      phys = {1'b0, r};
      if (m == `MODE_FIQ && r >= 4'd8 && r <= 4'd14)
        phys = {1'b0, r} + 5'd8;
      else if (r == 4'd13 || r == 4'd14)
      begin
        case (m)
          `MODE_IRQ: phys = {1'b0, r} + 5'd10;
          `MODE_SVC: phys = {1'b0, r} + 5'd12;
          `MODE_ABT: phys = {1'b0, r} + 5'd14;
          `MODE_UND: phys = {1'b0, r} + 5'd16;
          default: phys = {1'b0, r};
        endcase
      end
    end
  endfunction

  // saved status slot per exception mode
  function [2:0] sidx;
    input [4:0] m;
    begin
      case (m)
        `MODE_FIQ: sidx = 3'd0;
        `MODE_IRQ: sidx = 3'd1;
        `MODE_SVC: sidx = 3'd2;
        `MODE_ABT: sidx = 3'd3;
        default: sidx = 3'd4;
      endcase
    end
  endfunction

  // user and system modes have no saved word; they read zero
  wire has_saved = (mode_i != `MODE_USR) && (mode_i != `MODE_SYS);

  // banked reads
  assign rd_a_o = gpr_r[phys(mode_i, rd_idx_a_i)];
  assign rd_b_o = gpr_r[phys(mode_i, rd_idx_b_i)];
  assign saved_sw_o = has_saved ? saved_r[sidx(mode_i)] : 32'h0000_0000;

  // 31 general plus 5 saved words; the live word sits upstream
  always @(posedge sys_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      for (i = 0; i < `NUM_GPR; i = i + 1)
        gpr_r[i] <= 32'h0000_0000;
      for (i = 0; i < `NUM_SAVED_SW; i = i + 1)
        saved_r[i] <= 32'h0000_0000;
    end
    else
    begin
      if (wr_en_i)
        gpr_r[phys(wr_mode_i, wr_idx_i)] <= wr_data_i;
      if (sw_wr_i)
        saved_r[sidx(sw_mode_i)] <= sw_data_i;
    end
  end

endmodule // core_banked_regs

`default_nettype wire

// [hw/core_exception_entry.v]
`timescale 1ns/1ps
`default_nettype none
`include "core_exc_map.vh"

// How it works
// - fast request wins over a normal request pending in the same cycle.
// - five exception classes, each entering its own privileged mode.
// - entry clears compressed state; privileged modes stay in 32-bit state.
// - each exception mode uses its own stack pointer and link register.
// - fast mode also banks general registers eight to twelve.
// - 31 general and 6 status registers in all.
// - user mode sees fifteen general registers, program counter, status word.
// - a fast interrupt entry fetches from vector 0x1c.
// - fast entry latency bounded by 50 cycles.
// - without block loads the bound is 42 cycles.
// - in compressed state the bound is 22 cycles.
// - least latency is five cycles, synchroniser plus entry.
// - normal entry may wait indefinitely while fast handling runs.
// - breakpoint or watchpoint halts into debug with registers readable.
// - debugger programs break and watch registers; core applies them.
// - one 32-bit bus; data accesses of 8, 16 or 32 bits.
// - compressed 16-bit instruction set alongside the 32-bit one.
// - signed and unsigned 32x32 multiply and accumulate, 64-bit result.
module core_exception_entry
#(
  parameter DATA_W = 32
)
(
  input wire sys_clk_i,
  input wire sys_rst_i,
  input wire fast_interrupt_request_i,
  input wire normal_interrupt_request_i,
  input wire mem_abort_i,
  input wire undef_instr_i,
  input wire software_trap_instruction_i,
  input wire boundary_i,
  input wire block_load_instruction_i,
  input wire [31:0] ret_pc_i,
  input wire [31:0] fetch_addr_i,
  input wire [3:0] rd_idx_a_i,
  output wire [31:0] rd_a_o,
  input wire [3:0] rd_idx_b_i,
  output wire [31:0] rd_b_o,
  input wire wr_en_i,
  input wire [3:0] wr_idx_i,
  input wire [31:0] wr_data_i,
  input wire sw_wr_i,
  input wire [31:0] sw_wdata_i,
  input wire exc_return_i,
  output wire [31:0] current_status_word_o,
  output wire [4:0] mode_o,
  output wire compressed_o,
  output wire stall_o,
  output reg [31:0] vector_addr_o,
  output reg vector_valid_o,
  output reg latency_over_o,
  output reg [7:0] latency_o,
  input wire bus_req_i,
  input wire [DATA_W-1:0] bus_addr_i,
  input wire [1:0] bus_size_i,
  output reg [3:0] bus_be_o,
  input wire mul_go_i,
  input wire mul_signed_i,
  input wire multiply_accumulate_i,
  input wire [31:0] mul_a_i,
  input wire [31:0] mul_b_i,
  input wire [63:0] mul_acc_i,
  output reg [63:0] mul_res_o,
  input wire dbg_wr_i,
  input wire [1:0] dbg_sel_i,
  input wire [31:0] dbg_wdata_i,
  input wire dbg_resume_i,
  input wire [3:0] dbg_rd_idx_i,
  output wire debug_halt_o
);

  localparam ST_RUN = 5'b00001;
  localparam ST_ENT1 = 5'b00010;
  localparam ST_ENT2 = 5'b00100;
  localparam ST_VEC = 5'b01000;
  localparam ST_DBG = 5'b10000;

  reg [4:0] state_r;
  reg [4:0] state_nxt;
  reg [31:0] sw_r;
  reg [31:0] sw_nxt;
  reg fiq_s1_r, fiq_s2_r, irq_s1_r, irq_s2_r;
  reg [4:0] tgt_mode_r;
  reg [31:0] tgt_vec_r;
  reg [31:0] ret_pc_r;
  reg [31:0] bp_addr_r;
  reg [31:0] wp_addr_r;
  reg bp_en_r, wp_en_r;
  reg [7:0] lat_cnt_r;
  reg [7:0] lat_bound;
  reg [4:0] sel_mode;
  reg [31:0] sel_vec;
  reg sel_any;
  wire fiq_pend, irq_pend, privileged, hit, ent1, lat_run;
  wire [31:0] saved_sw;
  wire [4:0] cur_mode;

  // byte lanes for an access of given size at given offset
  function [3:0] lanes;
    input [1:0] size;
    input [1:0] off;
    begin
      case (size)
        `SIZE_BYTE: lanes = 4'h1 << off;
        `SIZE_HALF: lanes = off[1] ? 4'hc : 4'h3;
        default: lanes = 4'hf;
      endcase
    end
  endfunction

  // privileged when outside user mode
  function is_priv;
    input [4:0] m;
    begin
      is_priv = (m != `MODE_USR);
    end
  endfunction

  assign cur_mode = sw_r[4:0];
  assign privileged = is_priv(cur_mode);
  assign current_status_word_o = sw_r;
  assign mode_o = cur_mode;
  assign compressed_o = sw_r[`SW_T_BIT];
  assign stall_o = (state_r != ST_RUN);
  assign debug_halt_o = (state_r == ST_DBG);
  assign ent1 = (state_r == ST_ENT1);

  // two-stage synchronisers; only the second stage is used downstream
  always @(posedge sys_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      fiq_s1_r <= 1'b0;
      fiq_s2_r <= 1'b0;
      irq_s1_r <= 1'b0;
      irq_s2_r <= 1'b0;
    end
    else
    begin
      fiq_s1_r <= fast_interrupt_request_i;
      fiq_s2_r <= fiq_s1_r;
      irq_s1_r <= normal_interrupt_request_i;
      irq_s2_r <= irq_s1_r;
    end
  end

  // level requests rely on the controller holding them
  assign fiq_pend = fiq_s2_r & ~sw_r[`SW_F_BIT];
  assign irq_pend = irq_s2_r & ~sw_r[`SW_I_BIT];

  // abort first, then fast, normal, undefined, trap
  always @*
  begin
    sel_any = 1'b1;
    sel_mode = `MODE_SVC;
    sel_vec = `VEC_SWT;
    if (mem_abort_i)
    begin
      sel_mode = `MODE_ABT;
      sel_vec = `VEC_ABT;
    end
    else if (fiq_pend)
    begin
      sel_mode = `MODE_FIQ;
      sel_vec = `VEC_FIQ;
    end
    else if (irq_pend)
    begin
      sel_mode = `MODE_IRQ;
      sel_vec = `VEC_IRQ;
    end
    else if (undef_instr_i)
    begin
      sel_mode = `MODE_UND;
      sel_vec = `VEC_UND;
    end
    else if (!software_trap_instruction_i)
      sel_any = 1'b0;
  end

  // break on fetch address, watch on data address
  assign hit = (bp_en_r & boundary_i & (fetch_addr_i == bp_addr_r)) |
               (wp_en_r & bus_req_i & (bus_addr_i[31:0] == wp_addr_r));

  // debugger writes break and watch registers over the scan port
  always @(posedge sys_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      bp_addr_r <= 32'h0000_0000;
      wp_addr_r <= 32'h0000_0000;
      bp_en_r <= 1'b0;
      wp_en_r <= 1'b0;
    end
    else if (dbg_wr_i)
    begin
      case (dbg_sel_i)
        `DBG_BP_ADDR: bp_addr_r <= dbg_wdata_i;
        `DBG_WP_ADDR: wp_addr_r <= dbg_wdata_i;
        `DBG_ENABLES:
        begin
          bp_en_r <= dbg_wdata_i[0];
          wp_en_r <= dbg_wdata_i[1];
        end
        default: bp_en_r <= bp_en_r;
      endcase
    end
  end

  // entry sequencer: take at boundary, save, switch, vector
  always @*
  begin
    state_nxt = state_r;
    case (state_r)
      ST_RUN:
        if (hit)
          state_nxt = ST_DBG;
        else if (boundary_i && sel_any)
          state_nxt = ST_ENT1;
      ST_ENT1: state_nxt = ST_ENT2;
      ST_ENT2: state_nxt = ST_VEC;
      ST_VEC: state_nxt = ST_RUN;
      ST_DBG:
        if (dbg_resume_i)
          state_nxt = ST_RUN;
      default: state_nxt = ST_RUN;
    endcase
  end

  // status word updates: core writes, return, entry switch
  always @*
  begin
    sw_nxt = sw_r;
    if (state_r == ST_RUN && sw_wr_i)
      sw_nxt = sw_wdata_i;
    else if (state_r == ST_RUN && exc_return_i && privileged)
      sw_nxt = saved_sw;
    else if (state_r == ST_ENT2)
    begin
      sw_nxt[4:0] = tgt_mode_r;
      sw_nxt[`SW_T_BIT] = 1'b0;
      sw_nxt[`SW_I_BIT] = 1'b1;
      if (tgt_mode_r == `MODE_FIQ)
        sw_nxt[`SW_F_BIT] = 1'b1;
    end
    // a privileged mode never runs compressed code
    if (is_priv(sw_nxt[4:0]))
      sw_nxt[`SW_T_BIT] = 1'b0;
  end

  always @(posedge sys_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      state_r <= ST_RUN;
      sw_r <= `SW_RESET;
      tgt_mode_r <= `MODE_SVC;
      tgt_vec_r <= 32'h0000_0000;
      ret_pc_r <= 32'h0000_0000;
      vector_addr_o <= 32'h0000_0000;
      vector_valid_o <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      sw_r <= sw_nxt;
      vector_valid_o <= (state_r == ST_VEC);
      if (state_r == ST_RUN && state_nxt == ST_ENT1)
      begin
        tgt_mode_r <= sel_mode;
        tgt_vec_r <= sel_vec;
        ret_pc_r <= ret_pc_i;
      end
      if (state_r == ST_VEC)
        vector_addr_o <= tgt_vec_r;
    end
  end

  // count from the pin so the synchroniser delay is included; masked
  // lines do not count, so a normal wait under fast handling is not flagged
  assign lat_run = (fast_interrupt_request_i & ~sw_r[`SW_F_BIT]) |
                   (normal_interrupt_request_i & ~sw_r[`SW_I_BIT]) |
                   (stall_o & ~debug_halt_o);

  // latency watch; normal wait is unbounded under fast handling
  always @*
  begin
    if (sw_r[`SW_T_BIT])
      lat_bound = `LAT_MAX_COMP;
    else if (block_load_instruction_i)
      lat_bound = `LAT_MAX_BLOCK;
    else
      lat_bound = `LAT_MAX_PLAIN;
  end

  always @(posedge sys_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      lat_cnt_r <= 8'h00;
      latency_o <= 8'h00;
      latency_over_o <= 1'b0;
    end
    else
    begin
      if (vector_valid_o)
      begin
        latency_o <= lat_cnt_r;
        lat_cnt_r <= 8'h00;
      end
      else if (lat_run)
        lat_cnt_r <= (lat_cnt_r == 8'hff) ? 8'hff : lat_cnt_r + 8'h01;
      else
        lat_cnt_r <= 8'h00;
      // a late count outranks the clear of a new entry
      if (lat_cnt_r > lat_bound)
        latency_over_o <= 1'b1;
      else if (vector_valid_o)
        latency_over_o <= 1'b0;
    end
  end

  // long multiply with optional accumulate
  wire [32:0] mul_ax = {mul_signed_i & mul_a_i[31], mul_a_i};
  wire [32:0] mul_bx = {mul_signed_i & mul_b_i[31], mul_b_i};
  wire signed [65:0] mul_p = $signed(mul_ax) * $signed(mul_bx);
  wire [63:0] mul_add = multiply_accumulate_i ? mul_acc_i : 64'h0;

  always @(posedge sys_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      mul_res_o <= 64'h0000_0000_0000_0000;
    else if (mul_go_i)
      mul_res_o <= mul_p[63:0] + mul_add;
  end

  // byte enables on the shared bus
  always @(posedge sys_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      bus_be_o <= 4'h0;
    else
      bus_be_o <= bus_req_i ? lanes(bus_size_i, bus_addr_i[1:0]) : 4'h0;
  end

  // entry saves the link into the target mode bank; debug reads port b
  core_banked_regs u_regs
  (
    .sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i),
    .mode_i(cur_mode),
    .rd_idx_a_i(rd_idx_a_i),
    .rd_a_o(rd_a_o),
    .rd_idx_b_i(debug_halt_o ? dbg_rd_idx_i : rd_idx_b_i),
    .rd_b_o(rd_b_o),
    .wr_en_i(ent1 | (wr_en_i & ~stall_o)),
    .wr_mode_i(ent1 ? tgt_mode_r : cur_mode),
    .wr_idx_i(ent1 ? 4'he : wr_idx_i),
    .wr_data_i(ent1 ? ret_pc_r : wr_data_i),
    .sw_wr_i(ent1),
    .sw_mode_i(tgt_mode_r),
    .sw_data_i(sw_r),
    .saved_sw_o(saved_sw)
  );

endmodule // core_exception_entry

`default_nettype wire

// [tb/intc_model.sv]
`timescale 1ns/1ps
`default_nettype none
module intc_model
(
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic [1:0] raise_i,
  input wire logic [1:0] clear_i,
  output logic fast_o,
  output logic normal_o
);
  // lines are held, so a request cannot slip past the core's synchroniser
  always @(posedge sys_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      fast_o <= 1'h0;
      normal_o <= 1'h0;
    end
    else
    begin
      fast_o <= (fast_o | raise_i[0]) & ~clear_i[0];
      normal_o <= (normal_o | raise_i[1]) & ~clear_i[1];
    end
  end
endmodule // intc_model
`default_nettype wire

// [tb/core_exception_entry_sva.sv]
`timescale 1ns/1ps
`default_nettype none
`include "core_exc_map.vh"
module core_exception_entry_sva
#(
  parameter DATA_W = 32
)
(
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic fast_interrupt_request_i,
  input wire logic normal_interrupt_request_i,
  input wire logic [31:0] current_status_word_o,
  input wire logic [4:0] mode_o,
  input wire logic compressed_o,
  input wire logic stall_o,
  input wire logic [31:0] vector_addr_o,
  input wire logic vector_valid_o,
  input wire logic bus_req_i,
  input wire logic [DATA_W-1:0] bus_addr_i,
  input wire logic [1:0] bus_size_i,
  input wire logic [3:0] bus_be_o,
  input wire logic mul_go_i,
  input wire logic mul_signed_i,
  input wire logic multiply_accumulate_i,
  input wire logic [31:0] mul_a_i,
  input wire logic [31:0] mul_b_i,
  input wire logic [63:0] mul_acc_i,
  input wire logic [63:0] mul_res_o,
  input wire logic dbg_resume_i,
  input wire logic debug_halt_o
);
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (sys_rst_i);
  // expected values from the inputs, compared one edge later
  wire logic [63:0] mul_exp = (mul_signed_i ?
    {{32{mul_a_i[31]}}, mul_a_i} * {{32{mul_b_i[31]}}, mul_b_i} :
    {32'h0, mul_a_i} * {32'h0, mul_b_i}) +
    (multiply_accumulate_i ? mul_acc_i : 64'h0);
  wire logic [3:0] be_exp = bus_size_i == `SIZE_WORD ? 4'hf :
    (bus_size_i == `SIZE_HALF ? 4'h3 : 4'h1) << bus_addr_i[1:0];
  wire logic [4:0] vec_mode = vector_addr_o == `VEC_FIQ ? `MODE_FIQ :
    vector_addr_o == `VEC_IRQ ? `MODE_IRQ :
    vector_addr_o == `VEC_ABT ? `MODE_ABT :
    vector_addr_o == `VEC_UND ? `MODE_UND : `MODE_SVC;
  wire logic irq_vec = vector_valid_o && vector_addr_o == `VEC_IRQ;
  sequence s_fiq_vec;
    vector_valid_o && vector_addr_o == `VEC_FIQ;
  endsequence
  sequence s_quiet;
    !vector_valid_o [*5];
  endsequence
  property p_min_lat;
    $rose(fast_interrupt_request_i) && !stall_o |-> s_quiet;
  endproperty
  a_min_lat: assert property (p_min_lat)
    else $error("entry sooner than five cycles");
  property p_max_lat;
    $rose(fast_interrupt_request_i) && !debug_halt_o &&
      !current_status_word_o[`SW_F_BIT] |-> ##[1:50] s_fiq_vec;
  endproperty
  a_max_lat: assert property (p_max_lat)
    else $error("fast entry later than 50 cycles");
  property p_prio;
    $rose(fast_interrupt_request_i) && $rose(normal_interrupt_request_i) &&
      current_status_word_o[`SW_I_BIT:`SW_F_BIT] == 2'h0
      |-> !irq_vec throughout (##[1:50] s_fiq_vec);
  endproperty
  a_prio: assert property (p_prio)
    else $error("normal entry ahead of fast");
  property p_class;
    vector_valid_o |-> mode_o == vec_mode && current_status_word_o[`SW_I_BIT];
  endproperty
  a_class: assert property (p_class)
    else $error("mode does not match vector");
  property p_fvec;
    $rose(mode_o == `MODE_FIQ) |-> ##[1:3] s_fiq_vec;
  endproperty
  a_fvec: assert property (p_fvec)
    else $error("fast mode without fast vector");
  property p_priv32;
    mode_o != `MODE_USR |-> !compressed_o;
  endproperty
  a_priv32: assert property (p_priv32)
    else $error("compressed state in privileged mode");
  property p_be;
    bus_req_i |=> bus_be_o == $past(be_exp);
  endproperty
  a_be: assert property (p_be)
    else $error("byte lanes wrong");
  property p_mul;
    mul_go_i |=> mul_res_o == $past(mul_exp);
  endproperty
  a_mul: assert property (p_mul)
    else $error("multiply result wrong");
  property p_dbg_hold;
    debug_halt_o && !dbg_resume_i |=> debug_halt_o && stall_o;
  endproperty
  a_dbg_hold: assert property (p_dbg_hold)
    else $error("debug state left without resume");
  property p_dbg_exit;
    debug_halt_o && dbg_resume_i |=> !debug_halt_o && !stall_o;
  endproperty
  a_dbg_exit: assert property (p_dbg_exit)
    else $error("debug state kept after resume");
endmodule // core_exception_entry_sva
bind core_exception_entry core_exception_entry_sva #(.DATA_W(DATA_W)) u_sva
  (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
  .fast_interrupt_request_i(fast_interrupt_request_i),
  .normal_interrupt_request_i(normal_interrupt_request_i),
  .current_status_word_o(current_status_word_o), .mode_o(mode_o),
  .compressed_o(compressed_o), .stall_o(stall_o),
  .vector_addr_o(vector_addr_o), .vector_valid_o(vector_valid_o),
  .bus_req_i(bus_req_i), .bus_addr_i(bus_addr_i),
  .bus_size_i(bus_size_i), .bus_be_o(bus_be_o), .mul_go_i(mul_go_i),
  .mul_signed_i(mul_signed_i),
  .multiply_accumulate_i(multiply_accumulate_i), .mul_a_i(mul_a_i),
  .mul_b_i(mul_b_i), .mul_acc_i(mul_acc_i), .mul_res_o(mul_res_o),
  .dbg_resume_i(dbg_resume_i), .debug_halt_o(debug_halt_o));
`default_nettype wire

// [tb/core_exception_entry_tb.sv]
`timescale 1ns/1ps
`default_nettype none
`include "core_exc_map.vh"
module core_exception_entry_tb;
  logic sys_clk_i = 1'h0, sys_rst_i = 1'h1;
  logic fast_interrupt_request_i, normal_interrupt_request_i;
  logic mem_abort_i = 1'h0, undef_instr_i = 1'h0;
  logic software_trap_instruction_i = 1'h0, wr_en_i = 1'h0, sw_wr_i = 1'h0;
  logic exc_return_i = 1'h0, bus_req_i = 1'h0, mul_go_i = 1'h0;
  logic mul_signed_i = 1'h0, multiply_accumulate_i = 1'h0;
  logic dbg_wr_i = 1'h0, dbg_resume_i = 1'h0;
  // a boundary every cycle unless a scenario holds entry off
  logic boundary_i = 1'h1, block_load_instruction_i = 1'h0;
  wire logic [31:0] ret_pc_i = 32'h0000_0200;
  wire logic [3:0] rd_idx_b_i = 4'h8;
  logic [31:0] fetch_addr_i = 32'h0, wr_data_i = 32'h0, sw_wdata_i = 32'h0;
  logic [31:0] bus_addr_i = 32'h0, mul_a_i = 32'h0, mul_b_i = 32'h0;
  logic [31:0] dbg_wdata_i = 32'h0;
  logic [63:0] mul_acc_i = 64'h0;
  logic [3:0] rd_idx_a_i = 4'h0, wr_idx_i = 4'h0, dbg_rd_idx_i = 4'h0;
  logic [1:0] bus_size_i = 2'h0, dbg_sel_i = 2'h0, raise = 2'h0, clr = 2'h0;
  logic [31:0] rd_a_o, rd_b_o, current_status_word_o, vector_addr_o;
  logic [4:0] mode_o;
  logic [7:0] latency_o;
  logic [3:0] bus_be_o;
  logic [63:0] mul_res_o;
  logic compressed_o, stall_o, vector_valid_o, latency_over_o, debug_halt_o;
  logic [31:0] sv [3] = '{`VEC_ABT, `VEC_UND, `VEC_SWT};
  logic [4:0] sm [3] = '{`MODE_ABT, `MODE_UND, `MODE_SVC};
  int error_cnt = 0, n_checks = 0;
  core_exception_entry #(.DATA_W(32)) dut (.*);
  intc_model u_intc (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
    .raise_i(raise), .clear_i(clr), .fast_o(fast_interrupt_request_i),
    .normal_o(normal_interrupt_request_i));
  // 40 MHz core clock
  always #12.5 sys_clk_i = ~sys_clk_i;
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask
  task automatic complete_run;
    if (error_cnt == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic req(input logic [1:0] v);
    @(posedge sys_clk_i);
    raise <= v;
    @(posedge sys_clk_i);
    raise <= 2'h0;
  endtask
  // let the synchroniser drain before a return, or the line re-enters
  task automatic drop(input logic [1:0] v);
    @(posedge sys_clk_i);
    clr <= v;
    @(posedge sys_clk_i);
    clr <= 2'h0;
    tick(4);
  endtask
  task automatic leave;
    @(posedge sys_clk_i);
    exc_return_i <= 1'h1;
    @(posedge sys_clk_i);
    exc_return_i <= 1'h0;
  endtask
  task automatic wreg(input logic [3:0] idx, input logic [31:0] d);
    @(posedge sys_clk_i);
    {wr_en_i, wr_idx_i, wr_data_i} <= {1'h1, idx, d};
    @(posedge sys_clk_i);
    wr_en_i <= 1'h0;
  endtask
  task automatic rdchk(input logic [3:0] idx, input logic [31:0] e);
    @(posedge sys_clk_i);
    rd_idx_a_i <= idx;
    #1 chk(rd_a_o, e);
  endtask
  task automatic dbgw(input logic [1:0] s, input logic [31:0] d);
    @(posedge sys_clk_i);
    {dbg_wr_i, dbg_sel_i, dbg_wdata_i} <= {1'h1, s, d};
    @(posedge sys_clk_i);
    dbg_wr_i <= 1'h0;
  endtask
  task automatic wait_vec(input logic [31:0] va, input logic [4:0] md);
    int i;
    for (i = 0; i < 60 && vector_valid_o !== 1'h1; i++)
      @(posedge sys_clk_i) #1;
    chk(vector_valid_o, 1'h1);
    chk(vector_addr_o, va);
    chk(mode_o, md);
  endtask
  task automatic t_reset;
    chk(current_status_word_o, `SW_RESET);
    @(posedge sys_clk_i);
    {sw_wr_i, sw_wdata_i} <= {1'h1, 32'h0000_0030};
    @(posedge sys_clk_i);
    sw_wr_i <= 1'h0;
    #1 chk(compressed_o, 1'h1);
    chk(current_status_word_o, 32'h0000_0030);
  endtask
  task automatic t_fast;
    wreg(4'hd, 32'h0000_1111);
    wreg(4'h8, 32'h0000_2222);
    req(2'h1);
    wait_vec(`VEC_FIQ, `MODE_FIQ);
    chk(compressed_o, 1'h0);
    wreg(4'hd, 32'h0000_aaaa);
    wreg(4'h8, 32'h0000_bbbb);
    rdchk(4'hd, 32'h0000_aaaa);
    chk(latency_o >= `LAT_MIN && latency_o <= `LAT_MAX_COMP, 1'h1);
    chk(latency_over_o, 1'h0);
    drop(2'h1);
    leave;
    rdchk(4'hd, 32'h0000_1111);
    rdchk(4'h8, 32'h0000_2222);
    chk(compressed_o, 1'h1);
  endtask
  task automatic t_both;
    req(2'h3);
    wait_vec(`VEC_FIQ, `MODE_FIQ);
    tick(20);
    #1 chk(mode_o, `MODE_FIQ);
    drop(2'h1);
    leave;
    wait_vec(`VEC_IRQ, `MODE_IRQ);
    drop(2'h2);
    leave;
  endtask
  task automatic t_sync;
    for (int k = 0; k < 3; k++)
    begin
      @(posedge sys_clk_i);
      {mem_abort_i, undef_instr_i, software_trap_instruction_i} <= 3'h4 >> k;
      @(posedge sys_clk_i);
      {mem_abort_i, undef_instr_i, software_trap_instruction_i} <= 3'h0;
      wait_vec(sv[k], sm[k]);
      leave;
    end
  endtask
  task automatic t_bus;
    for (int s = 0; s < 3; s++)
      for (int o = 0; o < 4; o += 1 << s)
      begin
        @(posedge sys_clk_i);
        {bus_req_i, bus_size_i, bus_addr_i} <= {1'h1, 2'(s), 30'h40, 2'(o)};
        @(posedge sys_clk_i) #1;
        chk(bus_be_o, s == 2 ? 4'hf : (s == 1 ? 4'h3 : 4'h1) << o);
      end
    @(posedge sys_clk_i);
    bus_req_i <= 1'h0;
  endtask
  task automatic mul(input logic sg, input logic ac, input logic [31:0] a,
      input logic [31:0] b, input logic [63:0] acc);
    logic [63:0] e;
    e = sg ? {{32{a[31]}}, a} * {{32{b[31]}}, b} : {32'h0, a} * {32'h0, b};
    e = e + (ac ? acc : 64'h0);
    @(posedge sys_clk_i);
    {mul_go_i, mul_signed_i, multiply_accumulate_i} <= {1'h1, sg, ac};
    {mul_a_i, mul_b_i, mul_acc_i} <= {a, b, acc};
    @(posedge sys_clk_i) #1;
    chk(mul_res_o, e);
  endtask
  task automatic t_mul;
    mul(1'h1, 1'h0, 32'hffff_fffe, 32'h0000_0003, 64'h0);
    mul(1'h0, 1'h0, 32'hffff_ffff, 32'hffff_ffff, 64'h0);
    mul(1'h1, 1'h1, 32'h8000_0000, 32'h0000_0002, 64'h1);
    mul(1'h0, 1'h1, 32'hffff_ffff, 32'h0000_0002, 64'hffff_0000_0000_0000);
    @(posedge sys_clk_i);
    mul_go_i <= 1'h0;
  endtask
  // breakpoint, then watchpoint: halt, inspect a register, resume
  task automatic t_dbg;
    for (int k = 0; k < 2; k++)
    begin
      dbgw(2'(k), 32'h0000_0300);
      dbgw(`DBG_ENABLES, 32'h1 << k);
      @(posedge sys_clk_i);
      if (k == 0)
        fetch_addr_i <= 32'h0000_0300;
      else
        {bus_req_i, bus_addr_i} <= {1'h1, 32'h0000_0300};
      @(posedge sys_clk_i);
      {fetch_addr_i, bus_req_i, dbg_rd_idx_i} <= {32'h0, 1'h0, 4'hd};
      #1 chk({debug_halt_o, stall_o}, 2'h3);
      tick(3);
      #1 chk(rd_b_o, 32'h0000_1111);
      dbgw(`DBG_ENABLES, 32'h0);
      @(posedge sys_clk_i);
      dbg_resume_i <= 1'h1;
      @(posedge sys_clk_i);
      dbg_resume_i <= 1'h0;
      #1 chk(debug_halt_o, 1'h0);
    end
  endtask
  // 32-bit code, entry held off: bound 50 with a block load, else 42
  task automatic t_lat;
    @(posedge sys_clk_i);
    {sw_wr_i, sw_wdata_i} <= {1'h1, 32'h0000_0010};
    {boundary_i, block_load_instruction_i} <= 2'h1;
    @(posedge sys_clk_i);
    sw_wr_i <= 1'h0;
    req(2'h1);
    tick(44);
    block_load_instruction_i <= 1'h0;
    #1 chk(latency_over_o, 1'h0);
    @(posedge sys_clk_i);
    boundary_i <= 1'h1;
    #1 chk(latency_over_o, 1'h1);
    wait_vec(`VEC_FIQ, `MODE_FIQ);
    drop(2'h1);
    leave;
  endtask
  initial
  begin
    tick(5);
    sys_rst_i <= 1'h0;
    tick(1);
    #1;
    t_reset;
    t_fast;
    t_both;
    t_sync;
    t_bus;
    t_mul;
    t_dbg;
    t_lat;
    complete_run;
  end
  // watchdog far beyond the few hundred cycles the run needs
  initial
  begin
    tick(5000);
    error_cnt++;
    complete_run;
  end
endmodule // core_exception_entry_tb
`default_nettype wire
